// >>> oio_pkg.sv
// Purpose: Shared constants for the octal to serial audio output interface
// Assumes: 125 MHz system clock, mixer clocks sampled as pin inputs
// Notes:   Offsets, field positions, reset values and cycle counts live here
package oio_pkg;
  // ********************************
  // Host register map
  // ********************************
  localparam logic       REG_ID_SEL     = 1'b0;
  localparam logic       REG_CTRL_SEL   = 1'b1;
  localparam logic [7:0] CTRL_RESET     = 8'h60;
  localparam int         CTRL_DBL_BIT   = 0;
  localparam int         CTRL_SMUTE_BIT = 1;
  localparam int         CTRL_DRST_BIT  = 2;
  localparam int         CTRL_RLY_BIT   = 3;
  localparam int         CTRL_DEEMP_BIT = 4;
  localparam int         CTRL_OSEL_LSB  = 5;
  localparam logic [1:0] OSEL_OCT_0_1   = 2'h0;
  localparam logic [1:0] OSEL_OCT_8_9   = 2'h1;
  localparam logic [1:0] OSEL_OCT_10_11 = 2'h2;
  localparam logic [1:0] OSEL_ZERO      = 2'h3;

  // ********************************
  // Clock and frame timing
  // ********************************
  localparam int         SYS_CLK_HZ     = 125000000;
  localparam int         MCLK_48K_HZ    = 24576000;
  localparam int         MCLK_44K1_HZ   = 22579200;
  localparam int         FRAME_W        = 9;
  localparam int         SAMPLE_W       = 24;
  localparam int         SLOT_W         = 5;
  localparam logic [4:0] SLOT_LAST_BIT  = 5'h17;
  localparam logic [8:0] BIAS_UP_ON     = 9'h010;
  localparam logic [8:0] BIAS_UP_OFF    = 9'h0f0;
  localparam logic [8:0] BIAS_DN_ON     = 9'h110;
  localparam logic [8:0] BIAS_DN_OFF    = 9'h1f0;

  // ********************************
  // Configuration load
  // ********************************
  localparam int         CFG_LOAD_NS    = 1000;
  localparam int         CFG_LOAD_CYC   = (CFG_LOAD_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;
endpackage : oio_pkg

// >>> oio_sync3.sv
// Purpose: Three stage pin synchroniser with agreement filter
// Assumes: Input is asynchronous to clk
// Notes:   Output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module oio_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  input  wire logic [W-1:0] rstVal,
  output var  logic [W-1:0] dout
);
  logic [W-1:0] st1_reg;
  logic [W-1:0] st2_reg;
  logic [W-1:0] st3_reg;
  logic [W-1:0] out_reg;
  logic [W-1:0] outInit_reg;
  logic         live_reg;
  logic [W-1:0] agree;

  // Unresolved bits keep their old value
  assign agree = ~(st2_reg ^ st3_reg);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st1_reg <= '0;
      st2_reg <= '0;
      st3_reg <= '0;
      out_reg <= '0;
      live_reg <= 1'b0;
    end else if (ce) begin
      st1_reg <= din;
      st2_reg <= st1_reg;
      st3_reg <= st2_reg;
      live_reg <= 1'b1;
      out_reg <= live_reg ? ((agree & st3_reg) | (~agree & out_reg)) : rstVal;
    end
  end

  assign outInit_reg = rstVal;
  assign dout = live_reg ? out_reg : outInit_reg;
endmodule : oio_sync3
`default_nettype wire

// >>> oio_i2s_lane.sv
// Purpose: One converter lane, complement left and true right
// Assumes: Bit index counts 0..63 across one converter frame
// Notes:   Data starts one bit after the frame sync edge
`timescale 1ns/1ps
`default_nettype none
module oio_i2s_lane
  import oio_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                ce,
  input  wire logic                load,
  input  wire logic [SAMPLE_W-1:0] sample,
  input  wire logic [5:0]          bitIdx,
  input  wire logic                mute_n,
  output var  logic                sdata
);
  logic [SAMPLE_W-1:0] sample_reg;
  logic                sdata_reg;
  logic [4:0]          pos;
  logic                inWord;
  logic [4:0]          pick;
  logic                rawBit;
  logic                sdataNext;

  assign pos    = bitIdx[4:0];
  assign inWord = (pos != 5'h00) && (pos <= 5'h18);
  assign pick   = 5'(5'h18 - pos);
  assign rawBit = inWord ? sample_reg[pick] : 1'b0;
  // Left half carries the complement, right half the true value
  assign sdataNext = mute_n & (bitIdx[5] ? rawBit : (inWord & ~rawBit));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_reg <= '0;
      sdata_reg  <= 1'b0;
    end else if (ce) begin
      if (load) begin
        sample_reg <= sample;
      end
      sdata_reg <= sdataNext;
    end
  end

  assign sdata = sdata_reg;
endmodule : oio_i2s_lane
`default_nettype wire

// >>> oio_octal_out.sv
// Purpose: Octal link to eight converter lanes, host byte port, static controls
// Assumes: Mixer master and word clocks are sampled pins at 125 MHz
// Notes:   All local audio clocks derive from the sampled mixer clocks
`timescale 1ns/1ps
`default_nettype none
module oio_octal_out
  import oio_pkg::*;
#(
  parameter logic [7:0] BOARD_ID = 8'h5a, // Arbitrary identity value
  parameter int         CFG_CYC  = CFG_LOAD_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       dataStrobe_n,
  input  wire logic       slotSelect_n,
  input  wire logic       readNotWrite,
  input  wire logic       registerSelectBit,
  input  wire logic       unusedAddressBit,
  input  wire logic [7:0] hostDataIn,
  output var  logic [7:0] hostDataOut,
  output var  logic       hostDataOe_n,
  input  wire logic       globalMute_n,
  input  wire logic       mixerMasterClock,
  input  wire logic       mixerWordClock,
  input  wire logic       mixerHalfRateClock,
  input  wire logic       backplaneWordClock_n,
  input  wire logic       backplaneBitClock_n,
  input  wire logic       backplaneMasterClock,
  input  wire logic       backplaneReset_n,
  input  wire logic       powerGoodIn,
  input  wire logic       octalIn0,
  input  wire logic       octalIn1,
  input  wire logic       octalIn2,
  input  wire logic       octalIn3,
  input  wire logic       octalIn4,
  input  wire logic       octalIn5,
  output var  logic       converterFrameSync_n,
  output var  logic       converterBitClock_n,
  output var  logic       converterMasterClock,
  output var  logic       serialAudioOut0,
  output var  logic       serialAudioOut1,
  output var  logic       serialAudioOut2,
  output var  logic       serialAudioOut3,
  output var  logic       serialAudioOut4,
  output var  logic       serialAudioOut5,
  output var  logic       serialAudioOut6,
  output var  logic       serialAudioOut7,
  output var  logic       deEmphasisEnable,
  output var  logic       relayMute_n,
  output var  logic       converterSoftMute,
  output var  logic       converterReset_n,
  output var  logic       doubleRateEnable,
  output var  logic       supplyPumpClock,
  output var  logic       biasPumpPhaseUp_n,
  output var  logic       biasPumpPhaseDown_n,
  input  wire logic       configReload_n,
  output var  logic       configDone,
  output var  logic       configPromClock
);
  // ********************************
  // Pin synchronisers
  // ********************************
  // Ignored inputs stay unconnected on purpose
  logic [21:0] pinRaw;
  logic [21:0] pinSync;
  logic [21:0] pinRst;
  assign pinRaw = {configReload_n, globalMute_n, mixerWordClock, mixerMasterClock,
                   octalIn5, octalIn4, octalIn3, octalIn2, octalIn1, octalIn0,
                   hostDataIn, registerSelectBit, readNotWrite, slotSelect_n, dataStrobe_n};
  assign pinRst = {1'b1, 1'b1, 2'h0, 6'h00, 8'h00, 1'b0, 1'b1, 1'b1, 1'b1};

  oio_sync3 #(.W(22)) uPinSync (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .din   (pinRaw),
    .rstVal(pinRst),
    .dout  (pinSync)
  );

  logic       dsS;
  logic       selS_n;
  logic       rdS;
  logic       addrS;
  logic [7:0] dataS;
  logic [5:0] octS;
  logic       mckS;
  logic       wckS;
  logic       muteS_n;
  logic       reloadS_n;
  assign dsS       = pinSync[0];
  assign selS_n    = pinSync[1];
  assign rdS       = pinSync[2];
  assign addrS     = pinSync[3];
  assign dataS     = pinSync[11:4];
  assign octS      = pinSync[17:12];
  assign mckS      = pinSync[18];
  assign wckS      = pinSync[19];
  assign muteS_n   = pinSync[20];
  assign reloadS_n = pinSync[21];

  // ********************************
  // Host byte port
  // ********************************
  logic       dsPrev_reg;
  logic       latSel_n_reg;
  logic       latRd_reg;
  logic       latAddr_reg;
  logic [7:0] latData_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] rdData_reg;
  logic       strobeRise;
  logic       wrTake;
  logic [7:0] rdMux;
  logic       cfgBusy;

  assign strobeRise = dsS & ~dsPrev_reg;
  assign wrTake     = strobeRise & ~latSel_n_reg & ~latRd_reg & ~cfgBusy;
  assign ctrl_next  = (wrTake && latAddr_reg == REG_CTRL_SEL) ? latData_reg : ctrl_reg;
  assign rdMux      = (addrS == REG_ID_SEL) ? BOARD_ID : ctrl_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dsPrev_reg   <= 1'b1;
      latSel_n_reg <= 1'b1;
      latRd_reg    <= 1'b1;
      latAddr_reg  <= 1'b0;
      latData_reg  <= 8'h00;
      ctrl_reg     <= CTRL_RESET;
      rdData_reg   <= 8'h00;
    end else if (ce) begin
      dsPrev_reg <= dsS;
      // Hold the bus view from the last low strobe sample for the rising edge
      if (!dsS) begin
        latSel_n_reg <= selS_n;
        latRd_reg    <= rdS;
        latAddr_reg  <= addrS;
        latData_reg  <= dataS;
      end
      ctrl_reg   <= cfgBusy ? CTRL_RESET : ctrl_next;
      rdData_reg <= rdMux;
    end
  end

  // Enable follows the raw pins so the bus is released as soon as the strobe ends
  assign hostDataOe_n = slotSelect_n | dataStrobe_n | ~readNotWrite;
  assign hostDataOut  = rdData_reg;

  // ********************************
  // Static converter controls
  // ********************************
  logic [1:0] octSel;
  logic       dblRate;
  assign octSel            = ctrl_reg[CTRL_OSEL_LSB +: 2];
  assign dblRate           = ctrl_reg[CTRL_DBL_BIT];
  assign deEmphasisEnable  = ctrl_reg[CTRL_DEEMP_BIT];
  assign relayMute_n       = ctrl_reg[CTRL_RLY_BIT];
  assign converterSoftMute = ctrl_reg[CTRL_SMUTE_BIT];
  assign converterReset_n  = ctrl_reg[CTRL_DRST_BIT];
  assign doubleRateEnable  = dblRate;

  // ********************************
  // Configuration reload
  // ********************************
  logic [15:0] cfgCnt_reg;
  logic        cfgDone_reg;
  logic        promClk_reg;
  assign cfgBusy = ~cfgDone_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgCnt_reg  <= 16'h0000;
      cfgDone_reg <= 1'b0;
      promClk_reg <= 1'b0;
    end else if (ce) begin
      if (!reloadS_n) begin
        cfgCnt_reg  <= 16'h0000;
        cfgDone_reg <= 1'b0;
      end else if (!cfgDone_reg) begin
        cfgCnt_reg  <= 16'(cfgCnt_reg + 16'h0001);
        cfgDone_reg <= (cfgCnt_reg >= 16'(CFG_CYC - 1));
      end
      promClk_reg <= cfgDone_reg ? 1'b0 : ~promClk_reg;
    end
  end
  assign configDone      = cfgDone_reg;
  assign configPromClock = promClk_reg;

  // ********************************
  // Frame timing from the mixer clocks
  // ********************************
  logic               mckPrev_reg;
  logic               wckPrev_reg;
  logic [FRAME_W-1:0] mcnt_reg;
  logic               mckTick;
  logic               wckRise;
  assign mckTick = mckS & ~mckPrev_reg;
  assign wckRise = wckS & ~wckPrev_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mckPrev_reg <= 1'b0;
      wckPrev_reg <= 1'b0;
      mcnt_reg    <= '0;
    end else if (ce) begin
      mckPrev_reg <= mckS;
      wckPrev_reg <= wckS;
      if (wckRise) begin
        mcnt_reg <= '0;
      end else if (mckTick) begin
        mcnt_reg <= FRAME_W'(mcnt_reg + 1'b1);
      end
    end
  end

  // ********************************
  // Octal capture
  // ********************************
  logic       octA;
  logic       octB;
  logic [7:0] linkBit;
  logic [2:0] slotIdx;
  logic [4:0] slotBit;
  logic       bitTake;
  logic       wordEnd;
  logic [2:0] holdIdx;
  // Select field steers one pair, the last code silences both
  assign octA = (octSel == OSEL_OCT_0_1)   ? octS[0] :
                (octSel == OSEL_OCT_8_9)   ? octS[2] :
                (octSel == OSEL_OCT_10_11) ? octS[4] : 1'b0;
  assign octB = (octSel == OSEL_OCT_0_1)   ? octS[1] :
                (octSel == OSEL_OCT_8_9)   ? octS[3] :
                (octSel == OSEL_OCT_10_11) ? octS[5] : 1'b0;
  // Link bit lasts two master clocks, sampled in its middle
  assign linkBit = mcnt_reg[FRAME_W-1:1];
  assign slotIdx = linkBit[7:5];
  assign slotBit = linkBit[SLOT_W-1:0];
  assign bitTake = mckTick & ~mcnt_reg[0] & ~wckRise;
  assign wordEnd = bitTake & (slotBit == SLOT_LAST_BIT);
  assign holdIdx = slotIdx;

  logic [SAMPLE_W-1:0] shA_reg;
  logic [SAMPLE_W-1:0] shB_reg;
  logic [SAMPLE_W-1:0] holdA_reg [0:7];
  logic [SAMPLE_W-1:0] holdB_reg [0:7];
  logic [SAMPLE_W-1:0] shA_next;
  logic [SAMPLE_W-1:0] shB_next;
  assign shA_next = {shA_reg[SAMPLE_W-2:0], octA};
  assign shB_next = {shB_reg[SAMPLE_W-2:0], octB};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shA_reg <= '0;
      shB_reg <= '0;
      for (int i = 0; i < 8; i++) begin
        holdA_reg[i] <= '0;
        holdB_reg[i] <= '0;
      end
    end else if (ce) begin
      if (bitTake && slotBit <= SLOT_LAST_BIT) begin
        shA_reg <= shA_next;
        shB_reg <= shB_next;
      end
      if (wordEnd) begin
        holdA_reg[holdIdx] <= shA_next;
        holdB_reg[holdIdx] <= shB_next;
      end
    end
  end

  // ********************************
  // Converter clocks and lanes
  // ********************************
  logic [5:0] outBit;
  logic       bitHalf;
  logic       lanesLoad;
  logic       loadHigh;
  logic       fs_reg;
  logic       bck_reg;
  logic       mclk_reg;
  logic       vcc_reg;
  logic       bu_reg;
  logic       bd_reg;
  // Double rate halves the frame; the master clock keeps its rate
  assign outBit    = dblRate ? mcnt_reg[7:2] : mcnt_reg[8:3];
  assign bitHalf   = dblRate ? mcnt_reg[1] : mcnt_reg[2];
  assign lanesLoad = mckTick & (dblRate ? (mcnt_reg[7:0] == 8'h00) : (mcnt_reg == '0));
  // Single rate and the first double rate half use the last four slots
  assign loadHigh  = ~dblRate | ~mcnt_reg[8];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fs_reg   <= 1'b1;
      bck_reg  <= 1'b1;
      mclk_reg <= 1'b0;
      vcc_reg  <= 1'b0;
      bu_reg   <= 1'b1;
      bd_reg   <= 1'b1;
    end else if (ce) begin
      fs_reg   <= outBit[5];
      bck_reg  <= bitHalf;
      mclk_reg <= mcnt_reg[0];
      vcc_reg  <= mcnt_reg[2];
      bu_reg   <= ~(mcnt_reg >= BIAS_UP_ON && mcnt_reg < BIAS_UP_OFF);
      bd_reg   <= ~(mcnt_reg >= BIAS_DN_ON && mcnt_reg < BIAS_DN_OFF);
    end
  end
  assign converterFrameSync_n = fs_reg;
  assign converterBitClock_n  = bck_reg;
  assign converterMasterClock = mclk_reg;
  assign supplyPumpClock      = vcc_reg;
  assign biasPumpPhaseUp_n    = bu_reg;
  assign biasPumpPhaseDown_n  = bd_reg;

  logic [7:0] laneOut;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gLane
      logic [SAMPLE_W-1:0] laneSample;
      logic [2:0]          laneIdx;
      assign laneIdx    = {loadHigh, 2'(g / 2)};
      // Even channels from the first pair member, odd from the second
      assign laneSample = (g % 2 == 0) ? holdA_reg[laneIdx] : holdB_reg[laneIdx];
      oio_i2s_lane uLane (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .load  (lanesLoad),
        .sample(laneSample),
        .bitIdx(outBit),
        .mute_n(muteS_n),
        .sdata (laneOut[g])
      );
    end
  endgenerate

  assign serialAudioOut0 = laneOut[0];
  assign serialAudioOut1 = laneOut[1];
  assign serialAudioOut2 = laneOut[2];
  assign serialAudioOut3 = laneOut[3];
  assign serialAudioOut4 = laneOut[4];
  assign serialAudioOut5 = laneOut[5];
  assign serialAudioOut6 = laneOut[6];
  assign serialAudioOut7 = laneOut[7];
endmodule : oio_octal_out
`default_nettype wire

// >>> oio_octal_out_props.sv
// Purpose: Port level checks for the octal output block
// Assumes: One clock domain, ce held high by the bench
// Notes:   Bound to every oio_octal_out instance
`timescale 1ns/1ps
`default_nettype none
module oio_octal_out_props
  import oio_pkg::*;
#(
  parameter int CFG_CYC = 4
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic dataStrobe_n,
  input  wire logic slotSelect_n,
  input  wire logic readNotWrite,
  input  wire logic hostDataOe_n,
  input  wire logic globalMute_n,
  input  wire logic mixerWordClock,
  input  wire logic converterFrameSync_n,
  input  wire logic converterBitClock_n,
  input  wire logic converterMasterClock,
  input  wire logic serialAudioOut0,
  input  wire logic serialAudioOut7,
  input  wire logic deEmphasisEnable,
  input  wire logic relayMute_n,
  input  wire logic converterSoftMute,
  input  wire logic converterReset_n,
  input  wire logic doubleRateEnable,
  input  wire logic supplyPumpClock,
  input  wire logic biasPumpPhaseUp_n,
  input  wire logic biasPumpPhaseDown_n,
  input  wire logic configDone
);
  // ********************************
  // Helper counters
  // ********************************
  logic [7:0]  dsAge;
  logic [5:0]  wckAge;
  logic [15:0] upCnt;
  wire  [4:0]  ctlPins = {deEmphasisEnable, relayMute_n, converterReset_n, converterSoftMute,
                          doubleRateEnable};

  // Saturating ages, so a long idle spell never wraps into a false window
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dsAge  <= 8'hff;
      wckAge <= 6'h00;
      upCnt  <= 16'h0000;
    end else begin
      dsAge  <= $rose(dataStrobe_n) ? 8'h00 : dsAge + {7'h00, dsAge != 8'hff};
      wckAge <= $rose(mixerWordClock) ? 6'h00 : wckAge + {5'h00, wckAge != 6'h3f};
      upCnt  <= upCnt + {15'h0000, upCnt != 16'hffff};
    end
  end

  // ********************************
  // Properties
  // ********************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence sMclkFall;
    ##[3:8] $fell(converterMasterClock);
  endsequence
  sequence sPumpFall;
    ##[16:26] $fell(supplyPumpClock);
  endsequence

  a_oe_read_only: assert property (hostDataOe_n == (slotSelect_n | dataStrobe_n | !readNotWrite))
    else $error("bus enable wrong");
  a_ctl_after_write: assert property ($changed(ctlPins) |-> configDone && dsAge <= 8'h09)
    else $error("control moved without a write");
  a_ctl_reset_val: assert property (!configDone |-> ctlPins == CTRL_RESET[4:0])
    else $error("control not at reset value");
  a_mute_zero: assert property (!globalMute_n [*6] |-> !serialAudioOut0 && !serialAudioOut7)
    else $error("data not muted");
  a_bias_apart: assert property (!(!biasPumpPhaseUp_n && !biasPumpPhaseDown_n))
    else $error("bias phases overlap");
  a_pump_square: assert property ($rose(supplyPumpClock) |-> sPumpFall)
    else $error("pump clock half period off");
  a_mclk_half: assert property ($rose(converterMasterClock) |-> sMclkFall)
    else $error("master clock half period off");
  a_frame_on_wck: assert property ($fell(converterFrameSync_n) && !doubleRateEnable
                                   && $past(doubleRateEnable, 2) == doubleRateEnable
                                   |-> wckAge < 6'h18)
    else $error("frame start away from word clock");
  a_frame_on_bck: assert property ($changed(converterFrameSync_n)
                                   && $past(doubleRateEnable, 2) == doubleRateEnable
                                   |-> $fell(converterBitClock_n))
    else $error("frame sync off bit edge");
  a_data_on_bck: assert property ($changed(serialAudioOut0) && globalMute_n && $past(globalMute_n, 8)
                                   && $past(doubleRateEnable, 2) == doubleRateEnable
                                   |-> $fell(converterBitClock_n))
    else $error("data moved off bit edge");
  a_cfg_not_early: assert property ($rose(configDone) |-> upCnt >= CFG_CYC)
    else $error("config done too early");
  a_cfg_not_late: assert property (upCnt > CFG_CYC + 3 |-> configDone)
    else $error("config done missing");
endmodule : oio_octal_out_props

bind oio_octal_out oio_octal_out_props #(.CFG_CYC(CFG_CYC)) u_props (
  .clk(clk), .rst_n(rst_n), .dataStrobe_n(dataStrobe_n), .slotSelect_n(slotSelect_n),
  .readNotWrite(readNotWrite), .hostDataOe_n(hostDataOe_n), .globalMute_n(globalMute_n),
  .mixerWordClock(mixerWordClock), .converterFrameSync_n(converterFrameSync_n),
  .converterBitClock_n(converterBitClock_n), .converterMasterClock(converterMasterClock),
  .serialAudioOut0(serialAudioOut0), .serialAudioOut7(serialAudioOut7),
  .deEmphasisEnable(deEmphasisEnable), .relayMute_n(relayMute_n),
  .converterSoftMute(converterSoftMute), .converterReset_n(converterReset_n),
  .doubleRateEnable(doubleRateEnable), .supplyPumpClock(supplyPumpClock),
  .biasPumpPhaseUp_n(biasPumpPhaseUp_n), .biasPumpPhaseDown_n(biasPumpPhaseDown_n),
  .configDone(configDone));
`default_nettype wire

// >>> oio_mixer_model.sv
// Purpose: Mixer side model, master clock, word clock and six octal links
// Assumes: 24.576 MHz master clock, 512 master clocks per frame
// Notes:   Slot sample is {pattern, link index, slot}; status bits toggle
`timescale 1ns/1ps
`default_nettype none
module oio_mixer_model (
  input  wire logic        run,
  input  wire logic [15:0] pattern,
  output var  logic        masterClock,
  output var  logic        wordClock,
  output var  logic [5:0]  octal
);
  logic [8:0]  cnt;
  logic [7:0]  k;
  logic [23:0] word;

  initial begin
    masterClock = 1'b0;
    cnt         = 9'h1ff;
  end
  // Clock stands low until the bench starts it, so frames align from the first one
  always #20.345 masterClock = run ? !masterClock : 1'b0;
  always @(posedge masterClock) cnt <= cnt + 9'h001;
  assign k         = cnt[8:1];
  assign wordClock = !cnt[8];
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      word     = {pattern, 4'(i), 1'b0, k[7:5]};
      octal[i] = (k[4:0] < 5'h18) ? word[5'h17 - k[4:0]] : cnt[2];
    end
  end
endmodule : oio_mixer_model
`default_nettype wire

// >>> tb_oio_octal_out.sv
// Purpose: Self checking bench for the octal output block
// Assumes: Short config load, ce held high, reload held inactive
// Notes:   Driver notes expectations in queues, monitor compares them
`timescale 1ns/1ps
`default_nettype none
module tb_oio_octal_out
  import oio_pkg::*;
;
  localparam logic [7:0] BOARD_TST = 8'h3c; // Arbitrary identity value
  logic        clk = 1'b0, rst_n = 1'b0, ds_n = 1'b1, sel_n = 1'b1, rnw = 1'b1;
  logic        regSel = 1'b0, unusedBit = 1'b0, mute_n = 1'b1, run = 1'b0;
  logic [7:0]  dIn = 8'h00, dOut, ctl;
  logic [5:0]  junk = 6'h00, octal;
  logic [15:0] pattern = 16'h0000;
  logic        oe_n, mck, wck, fs_n, bck_n, done, prevDs, prevFs, prevBck;
  logic [7:0]  lanes;
  logic [4:0]  ctlPins;
  logic [23:0] expWord;
  logic [63:0] w [8];
  logic [7:0]  regQ [$];
  logic [4:0]  ctlQ [$];
  logic [23:0] laneQ [$];
  int          badCount = 0, nChecks = 0, frames = 0, f0, seed = 51328;

  always #4 clk = !clk;
  always @(posedge clk) junk <= 6'($random(seed));

  oio_octal_out #(.BOARD_ID(BOARD_TST), .CFG_CYC(4)) u_oio_octal_out (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .dataStrobe_n(ds_n), .slotSelect_n(sel_n),
    .readNotWrite(rnw), .registerSelectBit(regSel), .unusedAddressBit(unusedBit),
    .hostDataIn(dIn), .hostDataOut(dOut), .hostDataOe_n(oe_n), .globalMute_n(mute_n),
    .mixerMasterClock(mck), .mixerWordClock(wck), .mixerHalfRateClock(junk[0]),
    .backplaneWordClock_n(junk[1]), .backplaneBitClock_n(junk[2]),
    .backplaneMasterClock(junk[3]), .backplaneReset_n(junk[4]), .powerGoodIn(junk[5]),
    .octalIn0(octal[0]), .octalIn1(octal[1]), .octalIn2(octal[2]), .octalIn3(octal[3]),
    .octalIn4(octal[4]), .octalIn5(octal[5]), .converterFrameSync_n(fs_n),
    .converterBitClock_n(bck_n), .converterMasterClock(), .serialAudioOut0(lanes[0]),
    .serialAudioOut1(lanes[1]), .serialAudioOut2(lanes[2]), .serialAudioOut3(lanes[3]),
    .serialAudioOut4(lanes[4]), .serialAudioOut5(lanes[5]), .serialAudioOut6(lanes[6]),
    .serialAudioOut7(lanes[7]), .deEmphasisEnable(ctlPins[4]), .relayMute_n(ctlPins[3]),
    .converterSoftMute(ctlPins[1]), .converterReset_n(ctlPins[2]),
    .doubleRateEnable(ctlPins[0]), .supplyPumpClock(), .biasPumpPhaseUp_n(),
    .biasPumpPhaseDown_n(), .configReload_n(1'b1), .configDone(done), .configPromClock());

  oio_mixer_model u_mixer (.run(run), .pattern(pattern), .masterClock(mck), .wordClock(wck),
    .octal(octal));

  // ********************************
  // Compare and bus tasks
  // ********************************
  task automatic note(input logic ok, input string msg);
    nChecks++;
    if (!ok) begin
      badCount++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : note
  task automatic cmpReg(input logic [7:0] got, input logic [7:0] exp);
    note(got === exp, "register read");
  endtask : cmpReg
  task automatic cmpCtl(input logic [4:0] got, input logic [4:0] exp);
    note(got === exp, "control pins");
  endtask : cmpCtl
  task automatic cmpLane(input logic [23:0] got, input logic [23:0] exp);
    note(got === exp, "lane sample");
  endtask : cmpLane
  // No acknowledge on this port, so the strobe is simply held past the sync latency
  task automatic access(input logic rd, input logic a, input logic s_n, input logic [7:0] d);
    @(posedge clk);
    sel_n     <= s_n;
    rnw       <= rd;
    regSel    <= a;
    unusedBit <= 1'($random(seed));
    dIn       <= d;
    ds_n      <= 1'b0;
    repeat (10) @(posedge clk);
    ds_n      <= 1'b1;
    repeat (10) @(posedge clk);
    sel_n     <= 1'b1;
  endtask : access
  task automatic wr(input logic a, input logic [7:0] d);
    access(1'b0, a, 1'b0, d);
  endtask : wr
  task automatic rd(input logic a, input logic [7:0] e);
    regQ.push_back(e);
    access(1'b1, a, 1'b0, ~e);
  endtask : rd
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  // ********************************
  // Monitor
  // ********************************
  always @(posedge clk) begin
    prevDs  <= ds_n;
    prevFs  <= fs_n;
    prevBck <= bck_n;
    if (!prevDs && ds_n && rnw && !sel_n && regQ.size() > 0)
      cmpReg(dOut, regQ.pop_front());
    if (ctlQ.size() > 0)
      cmpCtl(ctlPins, ctlQ.pop_front());
    if (!prevBck && bck_n)
      for (int l = 0; l < 8; l++) w[l] <= {w[l][62:0], lanes[l]};
    if (prevFs && !fs_n) begin
      frames++;
      if (laneQ.size() >= 8) begin
        for (int l = 0; l < 8; l++) begin
          expWord = laneQ.pop_front();
          cmpLane(w[l][30:7], expWord);
          cmpLane(w[l][62:39], ~expWord);
        end
      end
    end
  end

  // ********************************
  // Stimulus
  // ********************************
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    run   <= 1'b1;
    ctlQ.push_back(CTRL_RESET[4:0]);
    for (int i = 0; i < 50 && done !== 1'b1; i++) @(posedge clk);
    rd(REG_CTRL_SEL, CTRL_RESET);
    rd(REG_ID_SEL, BOARD_TST);
    for (int n = 0; n < 4; n++) begin
      ctl = 8'($random(seed));
      wr(REG_CTRL_SEL, ctl);
      ctlQ.push_back(ctl[4:0]);
      rd(REG_CTRL_SEL, ctl);
    end
    access(1'b0, REG_CTRL_SEL, 1'b1, ~ctl);
    wr(REG_ID_SEL, ~ctl);
    rd(REG_CTRL_SEL, ctl);
    rd(REG_ID_SEL, BOARD_TST);
    // Each select value runs a few whole frames so the new pair is settled
    for (int s = 0; s < 4; s++) begin
      pattern <= 16'($random(seed));
      wr(REG_CTRL_SEL, {1'b0, 2'(s), 5'h0c});
      f0 = frames;
      wait (frames >= f0 + 3);
      for (int k = 0; k < 4; k++) begin
        laneQ.push_back(s == 3 ? 24'h000000 : {pattern, 4'(2 * s), 1'b0, 3'(4 + k)});
        laneQ.push_back(s == 3 ? 24'h000000 : {pattern, 4'(2 * s + 1), 1'b0, 3'(4 + k)});
      end
      wait (frames >= f0 + 4);
    end
    mute_n <= 1'b0;
    repeat (20) @(posedge clk);
    mute_n <= 1'b1;
    repeat (50) @(posedge clk);
    end_of_test();
  end

  initial begin
    repeat (90000) @(posedge clk);
    badCount++;
    end_of_test();
  end
endmodule : tb_oio_octal_out
`default_nettype wire
